/* verilog/bsc_control_regs.sv */
/*
  bsc_control_regs: configuration and control registers of a barometric sensor,
  sampling pacer, autozero, reboot/soft reset, block update and interrupt pin.
  assumes: an 8-bit register port from the serial front end on clk; raw samples
  and the sample strobe come from the converter on its own clock convClk.
*/
// Functional notes
// - pressure averaging field codes 0..3 select 8, 32, 128, 512 samples.
// - temperature averaging field codes 0..3 select 8, 16, 32, 64 samples.
// - device stays powered down until software sets the power bit.
// - rate field: one-shot, 1, 7, 12.5, 25 Hz; upper codes reserved.
// - differential circuitry runs only while its enable bit is set.
// - block update freezes an output between reading its parts.
// - autozero reset reloads reference from default registers, then self-clears.
// - wire-mode bit selects 4-wire SPI at 0, 3-wire at 1.
// - reboot copies trim at the next rate tick, or at once when the pacer is not running, then clears itself.
// - soft reset with reboot restores power-on configuration, then self-clears.
// - autozero captures present pressure as reference; output becomes difference.
// - one-shot bit starts one measurement at rate 000, clears on completion.
// - queue enable bit 6, watermark bit 5, mean decimation bit 4.
// - interrupt pin active high when polarity bit 0, else active low.
// - interrupt pad push-pull at 0, open-drain at 1.
// - pin source: routed data, high event, low event, or either.
// - routing register gates empty, watermark, overrun, data ready; top bits zero. Code stores bits 7:4 as written and reads them back.
// - reference is 24-bit two's complement subtracted from sensor pressure.
// - pressure-available flag sets on every new pressure sample.
module bsc_control_regs #(
  parameter int CLK_KHZ = 200000,
  parameter int DIVIDER = CLK_KHZ
) (
  // clocks and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic convClk,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // converter, convClk domain
  input wire logic sampleStrobe,
  input wire logic [23:0] rawPress,
  input wire logic [15:0] rawTemp,
  input wire logic [15:0] pressThreshold,
  output logic convStart,
  // queue flags from the storage logic, clk domain
  input wire logic queueEmpty,
  input wire logic queueWatermark,
  input wire logic queueOverrun,
  // configuration and trim
  output bsc_pkg::bsc_cfg_s cfg,
  output logic trimLoad,
  // interrupt pad
  output logic irqPinOut,
  output logic irqPinOe
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] avgCfg_q;
  logic [7:0] pwrCtrl_q;
  logic [7:0] bootCtrl_q;
  logic [7:0] irqPin_q;
  logic [7:0] irqRoute_q;
  logic [23:0] ref_q;
  logic [15:0] refDefault_q;
  logic [7:0] status_q;
  bsc_pkg::bsc_sample_s shown_q;
  logic pressFrozen_q;
  logic tempFrozen_q;
  logic [31:0] rateCnt_q;
  logic rateTick_q;
  logic rebootPend_q;
  logic trimLoad_q;
  logic convStart_q;
  logic [7:0] regRdata_q;
  logic irqOut_q;
  logic irqOe_q;
  bsc_pkg::bsc_cfg_s cfg_q;

  // ****************************************************************
  // sample crossing: toggle in convClk domain, words held stable
  // ****************************************************************
  logic sampToggle_q;
  bsc_pkg::bsc_sample_s convHold_q;
  logic startReq_q;
  logic [2:0] startSync_q;
  always_ff @(posedge convClk or negedge reset_n) begin
    if (!reset_n) begin
      sampToggle_q <= 1'b0;
      convHold_q <= '0;
      startSync_q <= 3'h0;
      convStart_q <= 1'b0;
    end else begin
      startSync_q <= {startSync_q[1:0], startReq_q};
      convStart_q <= startSync_q[2] ^ startSync_q[1];
      if (sampleStrobe) begin
        sampToggle_q <= ~sampToggle_q;
        convHold_q <= '{press: rawPress, temp: rawTemp};
      end
    end
  end
  assign convStart = convStart_q;

  logic [2:0] sampSync_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sampSync_q <= 3'h0;
    end else begin
      sampSync_q <= {sampSync_q[1:0], sampToggle_q};
    end
  end
  wire newSample = sampSync_q[2] ^ sampSync_q[1];

  // threshold is quasi-static configuration, compared unsynchronised against the shown pressure every clk cycle
  // ****************************************************************
  // decode
  // ****************************************************************
  wire wrPwr = regWrite && regAddr == bsc_pkg::PWR_CTRL_ADDR;
  wire wrBoot = regWrite && regAddr == bsc_pkg::BOOT_CTRL_ADDR;
  wire [2:0] rateSel = pwrCtrl_q[bsc_pkg::RATE_LSB +: 3];
  wire powerActive = pwrCtrl_q[bsc_pkg::POWER_ACTIVE_BIT];
  wire rateValid = rateSel <= bsc_pkg::RATE_25HZ;
  wire softReset = wrBoot && regWdata[bsc_pkg::SOFT_RESET_BIT]
    && regWdata[bsc_pkg::REBOOT_BIT];
  wire rdPressH = regRead && regAddr == bsc_pkg::POUT_H_ADDR;
  wire rdTempH = regRead && regAddr == bsc_pkg::TOUT_H_ADDR;
  wire rdPressLo = regRead && (regAddr == bsc_pkg::POUT_XL_ADDR
    || regAddr == bsc_pkg::POUT_L_ADDR);
  wire rdTempL = regRead && regAddr == bsc_pkg::TOUT_L_ADDR;
  wire blockUpdate = pwrCtrl_q[bsc_pkg::BLOCK_UPDATE_BIT];
  // pressure output is raw minus reference, two's complement
  wire [23:0] pressDiff = convHold_q.press - ref_q;
  wire [23:0] refDefault = {refDefault_q, 8'h00};
  wire oneShotActive = bootCtrl_q[bsc_pkg::ONE_SHOT_BIT]
    && rateSel == bsc_pkg::RATE_ONE_SHOT;

  // ****************************************************************
  // rate pacer: one tick per output-rate period
  // ****************************************************************
  logic [31:0] periodCycles;
  always_comb begin
    case (rateSel)
      3'h1: periodCycles = 32'(bsc_pkg::PERIOD_1HZ_MS * DIVIDER);
      3'h2: periodCycles = 32'(bsc_pkg::PERIOD_7HZ_MS * DIVIDER);
      3'h3: periodCycles = 32'(bsc_pkg::PERIOD_12HZ_MS * DIVIDER);
      3'h4: periodCycles = 32'(bsc_pkg::PERIOD_25HZ_MS * DIVIDER);
      default: periodCycles = 32'(bsc_pkg::PERIOD_1HZ_MS * DIVIDER);
    endcase
  end
  wire running = powerActive && rateValid && rateSel != bsc_pkg::RATE_ONE_SHOT;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rateCnt_q <= 32'h0;
      rateTick_q <= 1'b0;
    end else begin
      rateTick_q <= 1'b0;
      if (!running || rateCnt_q + 32'h1 >= periodCycles) begin
        rateCnt_q <= 32'h0;
        rateTick_q <= running;
      end else begin
        rateCnt_q <= rateCnt_q + 32'h1;
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avgCfg_q <= bsc_pkg::AVG_CFG_RST;
      pwrCtrl_q <= bsc_pkg::CTRL_RST;
      bootCtrl_q <= bsc_pkg::CTRL_RST;
      irqPin_q <= bsc_pkg::CTRL_RST;
      irqRoute_q <= bsc_pkg::CTRL_RST;
      ref_q <= 24'h0;
      refDefault_q <= 16'h0;
      rebootPend_q <= 1'b1;
      trimLoad_q <= 1'b0;
      startReq_q <= 1'b0;
    end else if (softReset) begin
      avgCfg_q <= bsc_pkg::AVG_CFG_RST;
      pwrCtrl_q <= bsc_pkg::CTRL_RST;
      bootCtrl_q <= bsc_pkg::CTRL_RST;
      irqPin_q <= bsc_pkg::CTRL_RST;
      irqRoute_q <= bsc_pkg::CTRL_RST;
      ref_q <= 24'h0;
      refDefault_q <= 16'h0;
      rebootPend_q <= 1'b1;
    end else begin
      trimLoad_q <= 1'b0;
      if (regWrite && regAddr == bsc_pkg::AVG_CFG_ADDR) avgCfg_q <= regWdata;
      if (wrPwr) pwrCtrl_q <= regWdata & 8'hFD;
      if (regWrite && regAddr == bsc_pkg::IRQ_PIN_ADDR) irqPin_q <= regWdata;
      if (regWrite && regAddr == bsc_pkg::IRQ_ROUTE_ADDR) irqRoute_q <= regWdata;
      if (regWrite && regAddr == bsc_pkg::RDEF_L_ADDR) refDefault_q[7:0] <= regWdata;
      if (regWrite && regAddr == bsc_pkg::RDEF_H_ADDR) refDefault_q[15:8] <= regWdata;
      if (regWrite && regAddr == bsc_pkg::REF_XL_ADDR) ref_q[7:0] <= regWdata;
      if (regWrite && regAddr == bsc_pkg::REF_L_ADDR) ref_q[15:8] <= regWdata;
      if (regWrite && regAddr == bsc_pkg::REF_H_ADDR) ref_q[23:16] <= regWdata;
      if (wrPwr && regWdata[bsc_pkg::AZ_RESET_BIT]) begin
        ref_q <= refDefault;
      end
      if (wrBoot) begin
        bootCtrl_q <= regWdata & 8'hFB;
        if (regWdata[bsc_pkg::REBOOT_BIT]) rebootPend_q <= 1'b1;
        if (regWdata[bsc_pkg::ONE_SHOT_BIT] && powerActive
          && rateSel == bsc_pkg::RATE_ONE_SHOT) begin
          startReq_q <= ~startReq_q;
        end
      end else begin
        // capture only once, then clear the one-shot bit when its sample arrives
        if (newSample && oneShotActive) begin
          bootCtrl_q[bsc_pkg::ONE_SHOT_BIT] <= 1'b0;
        end
        if (rebootPend_q && (rateTick_q || !running)) begin
          rebootPend_q <= 1'b0;
          trimLoad_q <= 1'b1;
          bootCtrl_q[bsc_pkg::REBOOT_BIT] <= 1'b0;
        end
      end
      if (bootCtrl_q[bsc_pkg::AUTOZERO_BIT] && newSample) begin
        ref_q <= convHold_q.press;
        bootCtrl_q[bsc_pkg::AUTOZERO_BIT] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // output registers with block update and status flags
  // ****************************************************************
  wire pressSet = newSample;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shown_q <= '0;
      pressFrozen_q <= 1'b0;
      tempFrozen_q <= 1'b0;
      status_q <= 8'h00;
    end else begin
      if (newSample && !(blockUpdate && pressFrozen_q)) shown_q.press <= pressDiff;
      if (newSample && !(blockUpdate && tempFrozen_q)) shown_q.temp <= convHold_q.temp;
      // a read of a lower part freezes until the high part is read
      if (rdPressLo) pressFrozen_q <= blockUpdate;
      if (rdPressH) pressFrozen_q <= 1'b0;
      if (rdTempL) tempFrozen_q <= blockUpdate;
      if (rdTempH) tempFrozen_q <= 1'b0;
      // set wins over the read-clear
      if (pressSet) begin
        status_q[bsc_pkg::PRESS_AVAIL_BIT] <= 1'b1;
        status_q[bsc_pkg::TEMP_AVAIL_BIT] <= 1'b1;
        status_q[bsc_pkg::PRESS_OVR_BIT] <= status_q[bsc_pkg::PRESS_AVAIL_BIT]
          && !rdPressH;
        status_q[bsc_pkg::TEMP_OVR_BIT] <= status_q[bsc_pkg::TEMP_AVAIL_BIT] && !rdTempH;
      end else begin
        if (rdPressH) begin
          status_q[bsc_pkg::PRESS_AVAIL_BIT] <= 1'b0;
          status_q[bsc_pkg::PRESS_OVR_BIT] <= 1'b0;
        end
        if (rdTempH) begin
          status_q[bsc_pkg::TEMP_AVAIL_BIT] <= 1'b0;
          status_q[bsc_pkg::TEMP_OVR_BIT] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  logic [7:0] rdMux;
  always_comb begin
    case (regAddr)
      bsc_pkg::REF_XL_ADDR: rdMux = ref_q[7:0];
      bsc_pkg::REF_L_ADDR: rdMux = ref_q[15:8];
      bsc_pkg::REF_H_ADDR: rdMux = ref_q[23:16];
      bsc_pkg::AVG_CFG_ADDR: rdMux = avgCfg_q;
      bsc_pkg::PWR_CTRL_ADDR: rdMux = pwrCtrl_q;
      bsc_pkg::BOOT_CTRL_ADDR: rdMux = bootCtrl_q;
      bsc_pkg::IRQ_PIN_ADDR: rdMux = irqPin_q;
      bsc_pkg::IRQ_ROUTE_ADDR: rdMux = irqRoute_q;
      bsc_pkg::STATUS_ADDR: rdMux = status_q;
      bsc_pkg::POUT_XL_ADDR: rdMux = shown_q.press[7:0];
      bsc_pkg::POUT_L_ADDR: rdMux = shown_q.press[15:8];
      bsc_pkg::POUT_H_ADDR: rdMux = shown_q.press[23:16];
      bsc_pkg::TOUT_L_ADDR: rdMux = shown_q.temp[7:0];
      bsc_pkg::TOUT_H_ADDR: rdMux = shown_q.temp[15:8];
      bsc_pkg::RDEF_L_ADDR: rdMux = refDefault_q[7:0];
      bsc_pkg::RDEF_H_ADDR: rdMux = refDefault_q[15:8];
      default: rdMux = 8'h00;
    endcase
  end

  // ****************************************************************
  // interrupt pin
  // ****************************************************************
  wire diffOn = pwrCtrl_q[bsc_pkg::DIFFERENTIAL_ENABLE_BIT];
  wire signed [23:0] diffVal = signed'(shown_q.press);
  wire signed [23:0] thrVal = signed'({pressThreshold, 8'h00});
  wire pressHigh = diffOn && diffVal > thrVal;
  wire pressLow = diffOn && diffVal < -thrVal;
  // route bits above bit 3 are ignored
  wire dataSig = |({queueEmpty, queueWatermark, queueOverrun,
    status_q[bsc_pkg::PRESS_AVAIL_BIT]} & irqRoute_q[3:0]);
  logic srcSig;
  always_comb begin
    case (irqPin_q[1:0])
      bsc_pkg::SRC_DATA: srcSig = dataSig;
      bsc_pkg::SRC_HIGH: srcSig = pressHigh;
      bsc_pkg::SRC_LOW: srcSig = pressLow;
      default: srcSig = pressHigh | pressLow;
    endcase
  end
  wire irqLevel = srcSig ^ irqPin_q[bsc_pkg::POLARITY_BIT];
  wire openDrain = irqPin_q[bsc_pkg::DRIVE_TYPE_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata_q <= 8'h00;
      irqOut_q <= 1'b0;
      irqOe_q <= 1'b1;
      cfg_q <= '0;
    end else begin
      regRdata_q <= rdMux;
      irqOut_q <= openDrain ? 1'b0 : irqLevel;
      irqOe_q <= openDrain ? !irqLevel : 1'b1;
      cfg_q.pressAvgSel <= avgCfg_q[bsc_pkg::PAVG_LSB +: 2];
      cfg_q.tempAvgSel <= avgCfg_q[bsc_pkg::TAVG_LSB +: 2];
      cfg_q.rateSel <= rateSel;
      cfg_q.powerActive <= powerActive && rateValid;
      cfg_q.differentialEnable <= diffOn;
      cfg_q.wireModeSel <= pwrCtrl_q[bsc_pkg::WIRE_MODE_BIT];
      cfg_q.queueEnable <= bootCtrl_q[bsc_pkg::QUEUE_EN_BIT];
      cfg_q.queueWatermarkEnable <= bootCtrl_q[bsc_pkg::QUEUE_WATERMARK_ENABLE_BIT];
      cfg_q.meanDecimationEnable <= bootCtrl_q[bsc_pkg::MEAN_DEC_BIT];
    end
  end

  assign regRdata = regRdata_q;
  assign irqPinOut = irqOut_q;
  assign irqPinOe = irqOe_q;
  assign cfg = cfg_q;
  assign trimLoad = trimLoad_q;

endmodule // bsc_control_regs

/* verilog/bsc_pkg.sv */
/*
  bsc_pkg: register map, field positions, reset values and shared types of the
  barometric sensor control block.
  assumes: 8-bit register bus from the serial front end, 7-bit addresses.
*/
package bsc_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [6:0] REF_XL_ADDR = 7'h08;
  localparam logic [6:0] REF_L_ADDR = 7'h09;
  localparam logic [6:0] REF_H_ADDR = 7'h0A;
  localparam logic [6:0] AVG_CFG_ADDR = 7'h10;
  localparam logic [6:0] PWR_CTRL_ADDR = 7'h20;
  localparam logic [6:0] BOOT_CTRL_ADDR = 7'h21;
  localparam logic [6:0] IRQ_PIN_ADDR = 7'h22;
  localparam logic [6:0] IRQ_ROUTE_ADDR = 7'h23;
  localparam logic [6:0] STATUS_ADDR = 7'h27;
  localparam logic [6:0] POUT_XL_ADDR = 7'h28;
  localparam logic [6:0] POUT_L_ADDR = 7'h29;
  localparam logic [6:0] POUT_H_ADDR = 7'h2A;
  localparam logic [6:0] TOUT_L_ADDR = 7'h2B;
  localparam logic [6:0] TOUT_H_ADDR = 7'h2C;
  localparam logic [6:0] RDEF_L_ADDR = 7'h39;
  localparam logic [6:0] RDEF_H_ADDR = 7'h3A;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] AVG_CFG_RST = 8'h05;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PAVG_LSB = 2;
  localparam int TAVG_LSB = 0;
  localparam int POWER_ACTIVE_BIT = 7;
  localparam int RATE_LSB = 4;
  localparam int DIFFERENTIAL_ENABLE_BIT = 3;
  localparam int BLOCK_UPDATE_BIT = 2;
  localparam int AZ_RESET_BIT = 1;
  localparam int WIRE_MODE_BIT = 0;
  localparam int REBOOT_BIT = 7;
  localparam int QUEUE_EN_BIT = 6;
  localparam int QUEUE_WATERMARK_ENABLE_BIT = 5;
  localparam int MEAN_DEC_BIT = 4;
  localparam int SOFT_RESET_BIT = 2;
  localparam int AUTOZERO_BIT = 1;
  localparam int ONE_SHOT_BIT = 0;
  localparam int POLARITY_BIT = 7;
  localparam int DRIVE_TYPE_BIT = 6;
  localparam int PRESS_AVAIL_BIT = 1;
  localparam int TEMP_AVAIL_BIT = 0;
  localparam int PRESS_OVR_BIT = 5;
  localparam int TEMP_OVR_BIT = 4;

  // ****************************************************************
  // codes and timing
  // ****************************************************************
  localparam logic [2:0] RATE_ONE_SHOT = 3'h0;
  localparam logic [2:0] RATE_25HZ = 3'h4;
  localparam logic [1:0] SRC_DATA = 2'h0;
  localparam logic [1:0] SRC_HIGH = 2'h1;
  localparam logic [1:0] SRC_LOW = 2'h2;
  // measurement periods in ms at each rate, 12.5 Hz given as 80 ms
  localparam int PERIOD_1HZ_MS = 1000;
  localparam int PERIOD_7HZ_MS = 143;
  localparam int PERIOD_12HZ_MS = 80;
  localparam int PERIOD_25HZ_MS = 40;

  typedef struct packed {
    logic [23:0] press;
    logic [15:0] temp;
  } bsc_sample_s;

  typedef struct packed {
    logic [1:0] pressAvgSel;
    logic [1:0] tempAvgSel;
    logic [2:0] rateSel;
    logic powerActive;
    logic differentialEnable;
    logic wireModeSel;
    logic queueEnable;
    logic queueWatermarkEnable;
    logic meanDecimationEnable;
  } bsc_cfg_s;

endpackage

/* sim/bsc_control_regs_sva.sv */
/*
  bsc_control_regs_sva: port checker for the control block.
  assumes: a write lands in cfg two clocks after it is taken.
*/
module bsc_control_regs_sva #(
  parameter int CLK_KHZ = 200000,
  parameter int DIVIDER = CLK_KHZ
) (
  // clocks and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic convClk,
  // register port
  input wire logic regWrite,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  // outputs
  input wire logic convStart,
  input wire bsc_pkg::bsc_cfg_s cfg,
  input wire logic trimLoad,
  input wire logic irqPinOut,
  input wire logic irqPinOe
);
  // ****************************************************************
  // write sequences
  // ****************************************************************
  sequence s_wr_avg;
    regWrite && regAddr == bsc_pkg::AVG_CFG_ADDR;
  endsequence
  sequence s_wr_pwr;
    regWrite && regAddr == bsc_pkg::PWR_CTRL_ADDR;
  endsequence
  // a combined soft reset overrides the enables, so it is left out here
  sequence s_wr_ctl;
    regWrite && regAddr == bsc_pkg::BOOT_CTRL_ADDR && !(regWdata[7] && regWdata[2]);
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_press_avg: assert property (@(posedge clk) disable iff (!reset_n)
    s_wr_avg |-> ##2 cfg.pressAvgSel == $past(regWdata[3:2], 2))
    else $error("pressure averaging code not applied");
  a_temp_avg: assert property (@(posedge clk) disable iff (!reset_n)
    s_wr_avg |-> ##2 cfg.tempAvgSel == $past(regWdata[1:0], 2))
    else $error("temperature averaging code not applied");
  a_power_active: assert property (@(posedge clk) disable iff (!reset_n)
    s_wr_pwr |-> ##2 cfg.powerActive == ($past(regWdata[7], 2) && $past(regWdata[6:4], 2) <= 3'h4))
    else $error("power state wrong after write");
  a_rate_sel: assert property (@(posedge clk) disable iff (!reset_n)
    s_wr_pwr |-> ##2 cfg.rateSel == $past(regWdata[6:4], 2))
    else $error("rate code not applied");
  a_diff_wire: assert property (@(posedge clk) disable iff (!reset_n)
    s_wr_pwr |-> ##2 cfg.differentialEnable == $past(regWdata[3], 2)
      && cfg.wireModeSel == $past(regWdata[0], 2))
    else $error("differential or wire mode wrong");
  a_queue_en: assert property (@(posedge clk) disable iff (!reset_n)
    s_wr_ctl |-> ##2 {cfg.queueEnable, cfg.queueWatermarkEnable, cfg.meanDecimationEnable}
      == $past(regWdata[6:4], 2))
    else $error("queue enables wrong");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!reset_n)
    regAddr == 7'h3F |=> regRdata == 8'h00)
    else $error("unmapped address read nonzero");
  a_trim_single: assert property (@(posedge clk) disable iff (!reset_n)
    trimLoad |=> !trimLoad)
    else $error("trim load longer than one cycle");
  a_conv_single: assert property (@(posedge convClk) disable iff (!reset_n)
    convStart |=> !convStart)
    else $error("conversion start longer than one cycle");
  a_pin_drive: assert property (@(posedge clk) disable iff (!reset_n)
    irqPinOut |-> irqPinOe)
    else $error("pin high while not driven");
endmodule // bsc_control_regs_sva

bind bsc_control_regs bsc_control_regs_sva #(.CLK_KHZ(CLK_KHZ), .DIVIDER(DIVIDER)) uSva (
  .clk(clk), .reset_n(reset_n), .convClk(convClk), .regWrite(regWrite), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata), .convStart(convStart), .cfg(cfg),
  .trimLoad(trimLoad), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe));

/* sim/bsc_conv_model.sv */
/*
  bsc_conv_model: converter partner, returns one sample per start request.
  assumes: convStart is a one-cycle pulse on convClk.
*/
module bsc_conv_model #(
  parameter int LATENCY = 4
) (
  // clock and reset
  input wire logic convClk,
  input wire logic reset_n,
  // request and sample
  input wire logic convStart,
  input wire logic [23:0] pressVal,
  input wire logic [15:0] tempVal,
  output logic sampleStrobe,
  output logic [23:0] rawPress,
  output logic [15:0] rawTemp
);
  int waitCnt;
  // outside the strobe the data toggles, so a late capture shows up
  always @(posedge convClk or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt <= 0;
      sampleStrobe <= 1'b0;
      rawPress <= 24'h0;
      rawTemp <= 16'h0;
    end else if (waitCnt == 1) begin
      waitCnt <= 0;
      sampleStrobe <= 1'b1;
      rawPress <= pressVal;
      rawTemp <= tempVal;
    end else begin
      waitCnt <= convStart ? LATENCY : (waitCnt > 1 ? waitCnt - 1 : 0);
      sampleStrobe <= 1'b0;
      rawPress <= ~rawPress;
      rawTemp <= ~rawTemp;
    end
  end
endmodule // bsc_conv_model

/* sim/tb_bsc_control_regs.sv */
/*
  tb_bsc_control_regs: self-checking bench of the control block.
  assumes: converter model on a 32 ns clock; DIVIDER shortened to 10.
*/
module tb_bsc_control_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, convClk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [6:0] regAddr = 7'h00;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic [2:0] qFlags = 3'h0;
  logic [23:0] pressVal = 24'h0, rawPress;
  logic [15:0] tempVal = 16'h0, rawTemp;
  logic sampleStrobe, convStart, trimLoad, irqPinOut, irqPinOe;
  bsc_pkg::bsc_cfg_s cfg;
  int error_cnt = 0, checked = 0, cycles = 0;
  bsc_control_regs #(.DIVIDER(10)) uut (.clk(clk), .reset_n(reset_n), .convClk(convClk),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .sampleStrobe(sampleStrobe), .rawPress(rawPress), .rawTemp(rawTemp),
    .pressThreshold(16'h0100), .convStart(convStart), .queueEmpty(qFlags[2]),
    .queueWatermark(qFlags[1]), .queueOverrun(qFlags[0]), .cfg(cfg), .trimLoad(trimLoad),
    .irqPinOut(irqPinOut), .irqPinOe(irqPinOe));
  bsc_conv_model uConv (.convClk(convClk), .reset_n(reset_n), .convStart(convStart),
    .pressVal(pressVal), .tempVal(tempVal), .sampleStrobe(sampleStrobe),
    .rawPress(rawPress), .rawTemp(rawTemp));
  initial forever #2.5 clk = ~clk;
  initial begin
    #7;
    forever #16 convClk = ~convClk;
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    d = regRdata;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic pinChk(input logic o, input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk({6'h0, irqPinOut, irqPinOe}, {6'h0, o, e});
  endtask
  task automatic oneShot(input logic [23:0] p, input logic [15:0] t, input logic [7:0] c);
    logic [7:0] d;
    int n;
    pressVal = p;
    tempVal = t;
    wr(7'h21, c);
    d = 8'h01;
    for (n = 0; n < 100 && d[0] !== 1'b0; n++) rd(7'h21, d);
    chk({7'h0, d[0]}, 8'h00);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rchk(7'h10, 8'h05);
    for (int a = 7'h20; a <= 7'h23; a++) rchk(a[6:0], 8'h00);
    chk({7'h0, cfg.powerActive}, 8'h00);
    wr(7'h3F, 8'hFF);
    rchk(7'h3F, 8'h00);
    wr(7'h27, 8'hFF);
    rchk(7'h27, 8'h00);
  endtask
  task automatic t_cfg;
    for (int i = 0; i < 4; i++) begin
      wr(7'h10, 8'(i * 4 + 3 - i));
      @(posedge clk);
      #1;
      chk({4'h0, cfg.pressAvgSel, cfg.tempAvgSel}, 8'(i * 4 + 3 - i));
    end
    for (int r = 0; r < 8; r++) begin
      wr(7'h20, 8'(8'h89 | r * 16));
      @(posedge clk);
      #1;
      chk({cfg.rateSel, cfg.powerActive, cfg.differentialEnable, cfg.wireModeSel, 2'h0},
        {3'(r), r <= 4, 4'hC});
    end
    wr(7'h21, 8'h70);
    @(posedge clk);
    #1;
    chk({cfg.queueEnable, cfg.queueWatermarkEnable, cfg.meanDecimationEnable}, 8'h07);
    wr(7'h21, 8'h00);
    wr(7'h20, 8'h80);
    repeat (60) @(posedge clk);
  endtask
  task automatic t_sample;
    logic [7:0] d;
    wr(7'h39, 8'h34);
    wr(7'h3A, 8'h12);
    wr(7'h20, 8'h82);
    rchk(7'h08, 8'h00);
    rchk(7'h09, 8'h34);
    rchk(7'h0A, 8'h12);
    rchk(7'h20, 8'h80);
    rd(7'h2A, d);
    rd(7'h2C, d);
    oneShot(24'h345678, 16'hABCD, 8'h01);
    rchk(7'h27, 8'h03);
    rchk(7'h28, 8'h78);
    rchk(7'h29, 8'h22);
    rchk(7'h2A, 8'h22);
    rchk(7'h2B, 8'hCD);
    rchk(7'h2C, 8'hAB);
    rchk(7'h27, 8'h00);
    wr(7'h20, 8'h84);
    rd(7'h28, d);
    oneShot(24'h400000, 16'h0000, 8'h01);
    rchk(7'h29, 8'h22);
    rchk(7'h2A, 8'h22);
    wr(7'h20, 8'h80);
    oneShot(24'h100000, 16'h0000, 8'h03);
    rchk(7'h0A, 8'h10);
    rchk(7'h21, 8'h00);
    oneShot(24'h100005, 16'h0000, 8'h01);
    rchk(7'h28, 8'h05);
    rchk(7'h2A, 8'h00);
  endtask
  task automatic t_irq;
    logic [7:0] d;
    wr(7'h23, 8'h01);
    oneShot(24'h000001, 16'h0001, 8'h01);
    pinChk(1'b1, 1'b1);
    wr(7'h22, 8'h80);
    pinChk(1'b0, 1'b1);
    wr(7'h22, 8'h40);
    pinChk(1'b0, 1'b0);
    wr(7'h22, 8'hC0);
    pinChk(1'b0, 1'b1);
    wr(7'h22, 8'h00);
    rd(7'h2A, d);
    pinChk(1'b0, 1'b1);
    for (int k = 0; k < 3; k++) begin
      qFlags = 3'(1 << k);
      wr(7'h23, 8'(2 << k));
      pinChk(1'b1, 1'b1);
      qFlags = 3'h0;
      pinChk(1'b0, 1'b1);
    end
    // shown pressure is now far below minus threshold: only the low event holds
    wr(7'h22, 8'h02);
    pinChk(1'b0, 1'b1);
    wr(7'h20, 8'h88);
    pinChk(1'b1, 1'b1);
    wr(7'h22, 8'h01);
    pinChk(1'b0, 1'b1);
    wr(7'h22, 8'h03);
    pinChk(1'b1, 1'b1);
    rchk(7'h22, 8'h03);
  endtask
  task automatic t_boot;
    int n;
    wr(7'h10, 8'h0A);
    wr(7'h21, 8'h80);
    for (n = 0; n < 100 && trimLoad !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk({7'h0, trimLoad}, 8'h01);
    rchk(7'h21, 8'h00);
    wr(7'h21, 8'h84);
    rchk(7'h10, 8'h05);
    rchk(7'h22, 8'h00);
    rchk(7'h21, 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge convClk);
    @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_cfg();
    t_sample();
    t_irq();
    t_boot();
    print_verdict();
  end
endmodule // tb_bsc_control_regs
